// file: logic/bal_pkg.sv
package bal_pkg;

	localparam int DATA_W   = 8;
	localparam int WORD_W   = 16;
	localparam int IO_AW    = 6;
	localparam int BIT_AW   = 3;
	localparam int IO_DEPTH = 32;

	// lowest bit-accessible i/o range
	localparam logic [5:0] IO_BIT_LO = 6'h00;
	localparam logic [5:0] IO_BIT_HI = 6'h1F;

	localparam logic [7:0] ALL_ONES   = 8'hFF;
	localparam logic [7:0] IO_RESET   = 8'h00;
	// bits that clear on writing one, per low i/o word
	localparam logic [7:0] W1C_MASK_DEFAULT = 8'h00;

	// cycle counts
	localparam int SINGLE_CYCLES = 1;
	localparam int WORD_CYCLES   = 2;

	// status flag positions
	localparam int FLAG_C = 0;
	localparam int FLAG_Z = 1;
	localparam int FLAG_N = 2;
	localparam int FLAG_V = 3;
	localparam int FLAG_S = 4;
	localparam int FLAG_H = 5;

	typedef enum logic [4:0] {
		OP_NONE      = 5'h00,
		OP_SUM       = 5'h01,
		OP_SUM_C     = 5'h02,
		OP_WORD_SUM  = 5'h03,
		OP_DIFF      = 5'h04,
		OP_DIFF_IMM  = 5'h05,
		OP_DIFF_B    = 5'h06,
		OP_DIFF_IMMB = 5'h07,
		OP_WORD_DIFF = 5'h08,
		OP_AND       = 5'h09,
		OP_AND_IMM   = 5'h0A,
		OP_OR        = 5'h0B,
		OP_OR_IMM    = 5'h0C,
		OP_XOR       = 5'h0D,
		OP_INVERT    = 5'h0E,
		OP_IO_SET    = 5'h0F,
		OP_IO_CLR    = 5'h10,
		OP_IO_SKIPH  = 5'h11,
		OP_IO_SKIPL  = 5'h12,
		OP_IO_WRITE  = 5'h13
	} bal_op_type;

	typedef enum logic [1:0] {
		ST_IDLE = 2'h0,
		ST_WORD = 2'h1
	} bal_state_type;

	typedef struct packed {
		bal_op_type        op;
		logic [7:0]        dest;
		logic [7:0]        destHigh;
		logic [7:0]        source;
		logic [7:0]        immediate;
		logic [IO_AW-1:0]  ioAddr;
		logic [BIT_AW-1:0] bitSel;
	} bal_req_type;

	typedef struct packed {
		logic [7:0] low;
		logic [7:0] high;
		logic       writeLow;
		logic       writeHigh;
		logic       skip;
	} bal_res_type;

endpackage

// file: logic/bal_io_mem.sv
module bal_io_mem
	import bal_pkg::*;
(
	input  wire logic                 mclk,
	input  wire logic                 rst,
	input  wire logic [4:0]           addr,
	input  wire logic                 wrEn,
	input  wire logic [DATA_W-1:0]    wrData,
	input  wire logic [DATA_W-1:0]    setHw,
	output logic      [DATA_W-1:0]    rdData,
	output logic      [DATA_W-1:0]    rdAsync
);
	logic [DATA_W-1:0] mem_reg [IO_DEPTH];

	assign rdAsync = mem_reg[addr];

	// word store, hardware set wins
	genvar g;
	generate
		for (g = 0; g < IO_DEPTH; g++) begin : gWord
			always_ff @(posedge mclk or posedge rst) begin
				if (rst) begin
					mem_reg[g] <= IO_RESET;
				end else if (wrEn && addr == 5'(g)) begin
					mem_reg[g] <= wrData | ((addr == 5'h00) ? setHw : 8'h00);
				end else if (g == 0) begin
					mem_reg[g] <= mem_reg[g] | setHw;
				end
			end
		end
	endgenerate

	always_ff @(posedge mclk or posedge rst) begin
		if (rst) begin
			rdData <= IO_RESET;
		end else begin
			rdData <= mem_reg[addr];
		end
	end
endmodule

// file: logic/bal_flags.sv
module bal_flags
	import bal_pkg::*;
(
	input  wire logic [7:0] result,
	input  wire logic       carryOut,
	input  wire logic       halfOut,
	input  wire logic       overflow,
	output logic      [5:0] flags
);
	// customary flag values
	always_comb begin
		flags         = 6'h00;
		flags[FLAG_C] = carryOut;
		flags[FLAG_Z] = (result == 8'h00);
		flags[FLAG_N] = result[7];
		flags[FLAG_V] = overflow;
		flags[FLAG_S] = result[7] ^ overflow;
		flags[FLAG_H] = halfOut;
	end
endmodule

// file: logic/bal_alu.sv
module bal_alu
	import bal_pkg::*;
(
	input  wire logic              mclk,
	input  wire logic              rst,
	input  wire logic              reqValid,
	input  wire bal_req_type       req,
	input  wire logic [7:0]        ioWriteData,
	input  wire logic [7:0]        w1cMask,
	input  wire logic [7:0]        hwFlagSet,
	output logic                   busy,
	output logic                   done,
	output bal_res_type            res,
	output logic      [7:0]        sreg,
	output logic      [7:0]        ioReadData,
	output logic                   ioBitError
);
	bal_state_type state_reg;
	bal_state_type state_next;
	logic [5:0]  flags;
	logic [7:0]  result;
	logic        carryOut;
	logic        halfOut;
	logic        overflow;
	logic [5:0]  updMask;
	logic [15:0] wordResult;
	logic        wordMode;
	logic [8:0]  tmp9;
	logic [4:0]  tmp5;
	logic [7:0]  opB;
	logic        cin;
	bal_req_type held_reg;
	logic        ioWrEn;
	logic [7:0]  ioWrData;
	logic [7:0]  ioCur;
	logic [7:0]  bitMask;

	function automatic logic isLowIo(input logic [IO_AW-1:0] a);
		return (a >= IO_BIT_LO) && (a <= IO_BIT_HI);
	endfunction

	function automatic logic [7:0] oneHot(input logic [BIT_AW-1:0] b);
		return 8'h01 << b;
	endfunction

	assign busy    = (state_reg == ST_WORD);
	assign bitMask = oneHot(held_reg.bitSel);

	// two-cycle word sequencing
	always_comb begin
		state_next = state_reg;
		case (state_reg)
			ST_IDLE: begin
				if (reqValid && (req.op == OP_WORD_SUM || req.op == OP_WORD_DIFF)) begin
					state_next = ST_WORD;
				end
			end
			ST_WORD: state_next = ST_IDLE;
			default: state_next = ST_IDLE;
		endcase
	end

	always_ff @(posedge mclk or posedge rst) begin
		if (rst) begin
			state_reg <= ST_IDLE;
		end else begin
			state_reg <= state_next;
		end
	end

	always_ff @(posedge mclk or posedge rst) begin
		if (rst) begin
			held_reg <= '0;
		end else if (reqValid && !busy) begin
			held_reg <= req;
		end
	end

	// byte and word arithmetic and logic
	always_comb begin
		opB      = held_reg.source;
		cin      = 1'b0;
		updMask  = 6'h00;
		wordMode = 1'b0;
		result   = 8'h00;
		carryOut = 1'b0;
		halfOut  = 1'b0;
		overflow = 1'b0;
		tmp9     = 9'h000;
		tmp5     = 5'h00;
		wordResult = 16'h0000;
		case (held_reg.op)
			OP_DIFF_IMM, OP_DIFF_IMMB, OP_AND_IMM, OP_OR_IMM: opB = held_reg.immediate;
			default: opB = held_reg.source;
		endcase
		case (held_reg.op)
			OP_SUM, OP_SUM_C: begin
				cin      = (held_reg.op == OP_SUM_C) ? sreg[FLAG_C] : 1'b0;
				tmp9     = {1'b0, held_reg.dest} + {1'b0, opB} + {8'h00, cin};
				tmp5     = {1'b0, held_reg.dest[3:0]} + {1'b0, opB[3:0]} + {4'h0, cin};
				result   = tmp9[7:0];
				carryOut = tmp9[8];
				halfOut  = tmp5[4];
				overflow = (held_reg.dest[7] == opB[7]) && (result[7] != opB[7]);
				updMask  = 6'b111111;
			end
			OP_DIFF, OP_DIFF_IMM, OP_DIFF_B, OP_DIFF_IMMB: begin
				cin      = (held_reg.op == OP_DIFF_B || held_reg.op == OP_DIFF_IMMB) ? sreg[FLAG_C] : 1'b0;
				tmp9     = {1'b0, held_reg.dest} - {1'b0, opB} - {8'h00, cin};
				tmp5     = {1'b0, held_reg.dest[3:0]} - {1'b0, opB[3:0]} - {4'h0, cin};
				result   = tmp9[7:0];
				carryOut = tmp9[8];
				halfOut  = tmp5[4];
				overflow = (held_reg.dest[7] != opB[7]) && (result[7] != held_reg.dest[7]);
				updMask  = 6'b111111;
			end
			OP_WORD_SUM, OP_WORD_DIFF: begin
				wordMode = 1'b1;
				if (held_reg.op == OP_WORD_SUM) begin
					{carryOut, wordResult} = {1'b0, held_reg.destHigh, held_reg.dest} + {9'h000, held_reg.immediate};
					overflow = !held_reg.destHigh[7] && wordResult[15];
				end else begin
					{carryOut, wordResult} = {1'b0, held_reg.destHigh, held_reg.dest} - {9'h000, held_reg.immediate};
					overflow = held_reg.destHigh[7] && !wordResult[15];
				end
				result  = wordResult[15:8];
				updMask = 6'b011111;
			end
			OP_AND, OP_AND_IMM, OP_OR, OP_OR_IMM, OP_XOR: begin
				case (held_reg.op)
					OP_AND, OP_AND_IMM: result = held_reg.dest & opB;
					OP_OR, OP_OR_IMM:   result = held_reg.dest | opB;
					default:            result = held_reg.dest ^ opB;
				endcase
				updMask = 6'b011110;
			end
			OP_INVERT: begin
				result   = ALL_ONES - held_reg.dest;
				carryOut = 1'b1;
				updMask  = 6'b011111;
			end
			default: updMask = 6'h00;
		endcase
	end

	bal_flags uFlags (
		.result   (result),
		.carryOut (carryOut),
		.halfOut  (halfOut),
		.overflow (overflow),
		.flags    (flags)
	);

	wire logic wordZero = (wordResult == 16'h0000);
	wire logic aluIssue = (state_reg == ST_IDLE) ? 1'b0 : 1'b1;
	logic exec_reg;

	always_ff @(posedge mclk or posedge rst) begin
		if (rst) begin
			exec_reg <= 1'b0;
		end else begin
			exec_reg <= reqValid && !busy && req.op != OP_WORD_SUM && req.op != OP_WORD_DIFF;
		end
	end

	always_ff @(posedge mclk or posedge rst) begin
		if (rst) begin
			sreg <= 8'h00;
		end else if (exec_reg || aluIssue) begin
			for (int i = 0; i < 6; i++) begin
				if (updMask[i]) begin
					sreg[i] <= (i == FLAG_Z && wordMode) ? wordZero : flags[i];
				end
			end
		end
	end

	always_comb begin
		ioWrEn   = 1'b0;
		ioWrData = ioCur;
		if (exec_reg && isLowIo(held_reg.ioAddr)) begin
			case (held_reg.op)
				OP_IO_SET: begin
					ioWrEn   = 1'b1;
					ioWrData = ioCur | bitMask;
				end
				OP_IO_CLR: begin
					ioWrEn   = 1'b1;
					ioWrData = (ioCur & ~bitMask);
				end
				OP_IO_WRITE: begin
					ioWrEn   = 1'b1;
					ioWrData = (ioWriteData & ~w1cMask) | (ioCur & w1cMask & ~ioWriteData);
				end
				default: ioWrEn = 1'b0;
			endcase
		end
	end

	bal_io_mem uIo (
		.mclk    (mclk),
		.rst     (rst),
		.addr    (held_reg.ioAddr[4:0]),
		.wrEn    (ioWrEn),
		.wrData  (ioWrData),
		.setHw   (hwFlagSet),
		.rdData  (ioReadData),
		.rdAsync (ioCur)
	);

	assign done = exec_reg || aluIssue;

	always_ff @(posedge mclk or posedge rst) begin
		if (rst) begin
			res        <= '0;
			ioBitError <= 1'b0;
		end else begin
			res.writeLow  <= 1'b0;
			res.writeHigh <= 1'b0;
			res.skip      <= 1'b0;
			ioBitError    <= 1'b0;
			if (aluIssue) begin
				res.low       <= wordResult[7:0];
				res.high      <= wordResult[15:8];
				res.writeLow  <= 1'b1;
				res.writeHigh <= 1'b1;
			end else if (exec_reg) begin
				res.low      <= result;
				res.writeLow <= (updMask != 6'h00);
				case (held_reg.op)
					OP_IO_SKIPH: res.skip <= isLowIo(held_reg.ioAddr) && (ioCur & bitMask) != 8'h00;
					OP_IO_SKIPL: res.skip <= isLowIo(held_reg.ioAddr) && (ioCur & bitMask) == 8'h00;
					default:     res.skip <= 1'b0;
				endcase
				if (held_reg.op >= OP_IO_SET && held_reg.op <= OP_IO_SKIPL) begin
					ioBitError <= !isLowIo(held_reg.ioAddr);
				end
			end
		end
	end

	sequence sWordTake;
		reqValid && !busy && (req.op == OP_WORD_SUM || req.op == OP_WORD_DIFF);
	endsequence
	sequence sWordRun;
		busy ##1 (res.writeHigh && !busy);
	endsequence
	property pWordTwo;
		@(posedge mclk) disable iff (rst)
		sWordTake |=> sWordRun;
	endproperty
	AST_WORD_TWO: assert property (pWordTwo) else $error("word op not two cycles");

	AST_ADD_ONE: assert property (@(posedge mclk) disable iff (rst)
		(reqValid && !busy && req.op == OP_SUM) |=> ##1 res.writeLow)
		else $error("add not one cycle");

	AST_LOGIC_C: assert property (@(posedge mclk) disable iff (rst)
		(exec_reg && held_reg.op == OP_AND) |=> sreg[FLAG_C] == $past(sreg[FLAG_C]))
		else $error("and changed carry");

	AST_INV_C: assert property (@(posedge mclk) disable iff (rst)
		(exec_reg && held_reg.op == OP_INVERT) |=> sreg[FLAG_C] && res.low == ~$past(held_reg.dest))
		else $error("invert wrong");

	AST_HIGH_IO: assert property (@(posedge mclk) disable iff (rst)
		(exec_reg && !isLowIo(held_reg.ioAddr)) |-> !ioWrEn)
		else $error("bit access above range");

	AST_ONE_BIT: assert property (@(posedge mclk) disable iff (rst)
		(ioWrEn && held_reg.op == OP_IO_CLR) |-> (ioWrData ^ ioCur) == (ioCur & bitMask))
		else $error("other bits rewritten");

	AST_SET_BIT: assert property (@(posedge mclk) disable iff (rst)
		(ioWrEn && held_reg.op == OP_IO_SET) |-> (ioWrData ^ ioCur) == (~ioCur & bitMask))
		else $error("set rewrote other bits");

	AST_W1C: assert property (@(posedge mclk) disable iff (rst)
		(ioWrEn && held_reg.op == OP_IO_WRITE) |->
		((ioWrData & w1cMask & ~ioWriteData) == (ioCur & w1cMask & ~ioWriteData)) &&
		((ioWrData & w1cMask & ioWriteData) == 8'h00))
		else $error("w1c wrong");

	AST_ZERO: assert property (@(posedge mclk) disable iff (rst)
		(exec_reg && held_reg.op == OP_XOR) |=> sreg[FLAG_Z] == (res.low == 8'h00))
		else $error("zero flag wrong");
endmodule

// file: sim/bal_regfile_model.sv
module bal_regfile_model
	import bal_pkg::*;
(
	input  wire logic        mclk,
	input  wire logic        rst,
	input  wire bal_res_type res,
	output logic      [7:0]  lowVal,
	output logic      [7:0]  highVal
);
	timeunit 1ns;
	timeprecision 1ns;

	always_ff @(posedge mclk or posedge rst) begin
		if (rst) begin
			lowVal  <= 8'h00;
			highVal <= 8'h00;
		end else begin
			if (res.writeLow)
				lowVal <= res.low;
			if (res.writeHigh)
				highVal <= res.high;
		end
	end
endmodule

// file: sim/bal_alu_tb.sv
module bal_alu_tb
	import bal_pkg::*;
;
	timeunit 1ns;
	timeprecision 1ns;

	logic        mclk;
	logic        rst;
	logic        reqValid;
	bal_req_type req;
	logic [7:0]  ioWriteData;
	logic [7:0]  w1cMask;
	logic [7:0]  hwFlagSet;
	logic        busy;
	logic        done;
	bal_res_type res;
	logic [7:0]  sreg;
	logic [7:0]  ioReadData;
	logic        ioBitError;
	logic [7:0]  lowVal;
	logic [7:0]  highVal;
	logic [7:0]  expS;
	logic        skipSeen;
	logic        errSeen;
	logic [7:0]  doneCnt;
	logic [7:0]  busyCnt;
	int          errors;
	int          tests_run;

	bal_alu bal_alu_i (.mclk(mclk), .rst(rst), .reqValid(reqValid), .req(req), .ioWriteData(ioWriteData),
		.w1cMask(w1cMask), .hwFlagSet(hwFlagSet), .busy(busy), .done(done), .res(res), .sreg(sreg),
		.ioReadData(ioReadData), .ioBitError(ioBitError));
	bal_regfile_model bal_regfile_model_i (.mclk(mclk), .rst(rst), .res(res), .lowVal(lowVal),
		.highVal(highVal));

	initial begin
		mclk = 1'b0;
		forever #50 mclk = ~mclk;
	end

	task automatic check(input logic [7:0] seen, input logic [7:0] want);
		tests_run++;
		if (seen !== want) begin
			errors++;
			$display("wrong value at %0t: saw %h want %h", $time, seen, want);
		end
	endtask

	task automatic summarize();
		$display("errors %0d tests_run %0d", errors, tests_run);
		if (errors == 0 && tests_run > 0)
			$display("NO MISMATCHES");
		else
			$display("MISMATCHES SEEN");
		$finish;
	endtask

	task automatic issue(input int n);
		@(negedge mclk);
		reqValid = 1'b1;
		@(posedge mclk);
		skipSeen = 1'b0;
		errSeen = 1'b0;
		doneCnt = 8'h00;
		busyCnt = 8'h00;
		repeat (n) begin
			@(negedge mclk);
			reqValid = 1'b0;
			skipSeen |= res.skip;
			errSeen |= ioBitError;
			doneCnt += 8'(done);
			busyCnt += 8'(busy);
		end
	endtask

	task automatic go(input bal_op_type o, input logic [7:0] d, input logic [7:0] dh, input logic [7:0] b);
		logic [16:0] w;
		logic [8:0]  r;
		logic        sub;
		logic        cin;
		logic        word;
		logic        imm;
		cin = (o inside {OP_SUM_C, OP_DIFF_B, OP_DIFF_IMMB}) ? expS[FLAG_C] : 1'b0;
		sub = o inside {OP_DIFF, OP_DIFF_IMM, OP_DIFF_B, OP_DIFF_IMMB, OP_WORD_DIFF};
		word = o inside {OP_WORD_SUM, OP_WORD_DIFF};
		imm = o inside {OP_DIFF_IMM, OP_DIFF_IMMB, OP_AND_IMM, OP_OR_IMM, OP_WORD_SUM, OP_WORD_DIFF};
		req = '0;
		req.op = o;
		req.dest = d;
		req.destHigh = dh;
		req.source = imm ? ~b : b;
		req.immediate = imm ? b : ~b;
		issue(word ? 4 : 3);
		r = '0;
		if (word) begin
			w = sub ? {1'b0, dh, d} - 17'(b) : {1'b0, dh, d} + 17'(b);
			expS[FLAG_C] = w[16];
			expS[FLAG_Z] = (w[15:0] == 16'h0000);
			expS[FLAG_N] = w[15];
			expS[FLAG_V] = sub ? (dh[7] & ~w[15]) : (~dh[7] & w[15]);
			expS[FLAG_S] = expS[FLAG_N] ^ expS[FLAG_V];
			r = {1'b0, w[7:0]};
			check(highVal, w[15:8]);
		end else if (o inside {OP_SUM, OP_SUM_C, OP_DIFF, OP_DIFF_IMM, OP_DIFF_B, OP_DIFF_IMMB}) begin
			r = sub ? {1'b0, d} - 9'(b) - 9'(cin) : {1'b0, d} + 9'(b) + 9'(cin);
			expS[FLAG_C] = r[8];
			expS[FLAG_H] = sub ? (5'(d[3:0]) < 5'(b[3:0]) + 5'(cin)) : (5'(d[3:0]) + 5'(b[3:0]) + 5'(cin) > 5'h0F);
			expS[FLAG_V] = sub ? ((d[7] ^ b[7]) & (r[7] ^ d[7])) : (~(d[7] ^ b[7]) & (r[7] ^ d[7]));
		end else begin
			case (o)
				OP_AND, OP_AND_IMM: r = {1'b0, d & b};
				OP_OR, OP_OR_IMM: r = {1'b0, d | b};
				OP_XOR: r = {1'b0, d ^ b};
				default: r = {1'b0, ALL_ONES - d};
			endcase
			expS[FLAG_V] = 1'b0;
			if (o == OP_INVERT)
				expS[FLAG_C] = 1'b1;
		end
		if (!word) begin
			expS[FLAG_Z] = (r[7:0] == 8'h00);
			expS[FLAG_N] = r[7];
		end
		check(lowVal, r[7:0]);
		check(sreg & (word ? 8'h3F : 8'h2F), expS & (word ? 8'h3F : 8'h2F));
		check(doneCnt, 8'h01);
		check(busyCnt, word ? 8'h01 : 8'h00);
	endtask

	task automatic iop(input bal_op_type o, input logic [5:0] a, input logic [2:0] bt, input logic [7:0] wd);
		req = '0;
		req.op = o;
		req.ioAddr = a;
		req.bitSel = bt;
		ioWriteData = wd;
		issue(3);
		check(doneCnt, 8'h01);
	endtask

	task automatic arith_ops();
		go(OP_SUM, 8'h0F, 8'h00, 8'h01);
		go(OP_SUM, 8'h7F, 8'h00, 8'h01);
		go(OP_SUM, 8'hFF, 8'h00, 8'h01);
		go(OP_SUM_C, 8'h10, 8'h00, 8'h20);
		go(OP_DIFF, 8'h10, 8'h00, 8'h01);
		go(OP_DIFF_IMM, 8'h00, 8'h00, 8'h01);
		go(OP_DIFF_B, 8'h80, 8'h00, 8'h00);
		go(OP_DIFF_IMMB, 8'h05, 8'h00, 8'h05);
	endtask

	task automatic logic_ops();
		go(OP_SUM, 8'h8F, 8'h00, 8'h81);
		go(OP_AND, 8'hF0, 8'h00, 8'h0F);
		go(OP_AND_IMM, 8'hF3, 8'h00, 8'h81);
		go(OP_OR, 8'h00, 8'h00, 8'h00);
		go(OP_OR_IMM, 8'h41, 8'h00, 8'h90);
		go(OP_XOR, 8'hAA, 8'h00, 8'hFF);
		go(OP_INVERT, 8'h00, 8'h00, 8'h00);
		go(OP_INVERT, 8'hFF, 8'h00, 8'h00);
	endtask

	task automatic word_ops();
		go(OP_WORD_SUM, 8'hFF, 8'h7F, 8'h01);
		go(OP_WORD_SUM, 8'hFF, 8'hFF, 8'h01);
		go(OP_WORD_DIFF, 8'h00, 8'h00, 8'h01);
		go(OP_WORD_DIFF, 8'h00, 8'h80, 8'h01);
	endtask

	task automatic io_ops();
		@(negedge mclk);
		hwFlagSet = 8'h80;
		@(negedge mclk);
		hwFlagSet = 8'h00;
		iop(OP_IO_SET, 6'h00, 3'h0, 8'h00);
		iop(OP_IO_SKIPH, 6'h00, 3'h7, 8'h00);
		check({7'h00, skipSeen}, 8'h01);
		check(ioReadData, 8'h81);
		iop(OP_IO_WRITE, 6'h00, 3'h0, 8'h00);
		iop(OP_IO_SKIPH, 6'h00, 3'h0, 8'h00);
		check(ioReadData, 8'h80);
		iop(OP_IO_WRITE, 6'h00, 3'h0, 8'h80);
		iop(OP_IO_SKIPL, 6'h00, 3'h7, 8'h00);
		check({7'h00, skipSeen}, 8'h01);
		check(ioReadData, 8'h00);
		iop(OP_IO_SET, 6'h1F, 3'h3, 8'h00);
		iop(OP_IO_SKIPL, 6'h1F, 3'h3, 8'h00);
		check({7'h00, skipSeen}, 8'h00);
		iop(OP_IO_CLR, 6'h1F, 3'h3, 8'h00);
		iop(OP_IO_SKIPH, 6'h1F, 3'h3, 8'h00);
		check({7'h00, skipSeen}, 8'h00);
		check(ioReadData, 8'h00);
		iop(OP_IO_SET, 6'h20, 3'h0, 8'h00);
		check({7'h00, errSeen}, 8'h01);
		check(ioReadData, 8'h00);
	endtask

	task automatic refuse_busy();
		req = '0;
		req.op = OP_WORD_SUM;
		req.dest = 8'h10;
		req.immediate = 8'h01;
		@(negedge mclk);
		reqValid = 1'b1;
		@(negedge mclk);
		req.op = OP_SUM;
		req.dest = 8'h55;
		@(negedge mclk);
		reqValid = 1'b0;
		repeat (3) @(negedge mclk);
		check(lowVal, 8'h11);
		check(highVal, 8'h00);
	endtask

	task automatic flag_race();
		req = '0;
		req.op = OP_IO_WRITE;
		ioWriteData = 8'h80;
		@(negedge mclk);
		reqValid = 1'b1;
		@(negedge mclk);
		reqValid = 1'b0;
		hwFlagSet = 8'h80;
		@(negedge mclk);
		hwFlagSet = 8'h00;
		iop(OP_IO_SKIPH, 6'h00, 3'h7, 8'h00);
		check({7'h00, skipSeen}, 8'h01);
		check(ioReadData, 8'h80);
	endtask

	initial begin
		errors = 0;
		tests_run = 0;
		rst = 1'b1;
		reqValid = 1'b0;
		req = '0;
		ioWriteData = 8'h00;
		w1cMask = 8'h80;
		hwFlagSet = 8'h00;
		expS = 8'h00;
		repeat (2) @(negedge mclk);
		rst = 1'b0;
		check(sreg, 8'h00);
		arith_ops();
		logic_ops();
		word_ops();
		refuse_busy();
		io_ops();
		flag_race();
		summarize();
	end
endmodule
